// ==== src/pprf_regfile.sv ====
// module: paged register file of the transceiver, wishbone top
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
module pprf_regfile #(
	parameter logic [2:0] LEGACY_SPD = 3'h0 // max legacy speed field
) (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// wishbone slave
	input  wire pprf_pkg::pprf_wb_req_t wb_req_i,
	output logic                        wb_ack_o,
	output logic [31:0]                 wb_dat_o,
	// node state from the arbiter
	input  wire logic [5:0]             phy_id_i,
	input  wire logic                   root_i,
	input  wire logic                   cps_pin_i,
	input  wire logic                   blink_i,
	input  wire logic                   bus_reset_i,
	// control to the arbiter
	output logic                        root_holdoff_o,
	output logic                        bus_reset_req_o,
	output logic [5:0]                  gap_count_o,
	output logic                        standby_en_o,
	output logic                        link_active_o,
	output logic                        contender_o,
	output logic [2:0]                  pwr_class_o,
	output logic [7:0]                  int_enables_o,
	output logic [1:0]                  bridge_o,
	output logic [2:0]                  page_o,
	output logic [3:0]                  port_sel_o
);
	import pprf_pkg::*;

	// handshake
	logic        take;       // request taken this edge
	logic        commit;     // write lands this edge
	logic [3:0]  idx;        // register index
	logic        mapped;     // inside the register window
	// decode
	logic        is_base;    // index is a base register
	logic        page_live;  // paged index backed by storage
	logic [1:0]  bank;       // storage bank of the page
	// writable state
	logic        rhb_q;      // root holdoff
	logic        ibr_q;      // bus reset request
	logic [5:0]  gap_q;      // arbitration gap count
	logic [1:0]  resets_q;   // bus resets without gap write
	logic        sren_q;     // standby enable
	logic        lctrl_q;    // link active
	logic        cont_q;     // contender
	logic [2:0]  pwr_q;      // power class
	logic [7:0]  inten_q;    // interrupt and feature enables
	logic [1:0]  bridge_q;   // bridge field
	logic [2:0]  page_q;     // selected page
	logic [3:0]  port_q;     // selected port
	// paged storage, pages 0, 1 and 7
	logic [7:0]  page_mem_q [PPRF_NUM_BANKS][PPRF_PAGE_REGS];
	// cable power synchroniser
	logic        cps_meta_q; // first stage
	logic        cps_q;      // settled level
	// read path
	logic [7:0]  rd_byte;    // byte selected for reading
	logic [31:0] dat_q;      // registered read data
	logic [7:0]  wr_byte;    // write data lane 0
	// write strobes of the writable base registers
	logic        wr_gap;     // register one written
	logic        wr_speed;   // register three written
	logic        wr_link;    // register four written
	logic        wr_inten;   // register five written
	logic        wr_legacy;  // register six written
	logic        wr_page;    // register seven written
	// helpers for the checks below
	logic [2:0]  wr_pg_val;  // page field of the write data
	logic [3:0]  wr_pt_val;  // port field of the write data
	logic [7:0]  p0_byte;    // page zero byte at the index

	assign wr_byte = wb_req_i.dat[7:0];

	// a write to register which lands on this edge
	function automatic logic wr_hit(input logic cm, input logic mp,
		input logic [3:0] ix, input logic [3:0] which);
		return cm && mp && (ix == which);
	endfunction : wr_hit

	// one strobe per writable base register [R5]
	assign wr_gap    = wr_hit(commit, mapped, idx, PPRF_IDX_GAP_CTRL);
	assign wr_speed  = wr_hit(commit, mapped, idx, PPRF_IDX_SPEED);
	assign wr_link   = wr_hit(commit, mapped, idx, PPRF_IDX_LINK_PWR);
	assign wr_inten  = wr_hit(commit, mapped, idx, PPRF_IDX_INT_EN);
	assign wr_legacy = wr_hit(commit, mapped, idx, PPRF_IDX_LEGACY);
	assign wr_page   = wr_hit(commit, mapped, idx, PPRF_IDX_PAGE_SEL);

	// values the checks compare against
	assign wr_pg_val = wr_byte[PPRF_PAGE_LSB +: 3];
	assign wr_pt_val = wr_byte[PPRF_PORT_LSB +: 4];
	assign p0_byte   = page_mem_q[PPRF_BANK_P0][idx[2:0]];

	// bus handshake
	pprf_wb_port u_port (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.wb_req_i (wb_req_i),
		.ack_o    (wb_ack_o),
		.take_o   (take),
		.commit_o (commit),
		.idx_o    (idx),
		.mapped_o (mapped)
	);

	// page decode of the current index
	pprf_page_map u_map (
		.idx_i  (idx),
		.page_i (page_q),
		.base_o (is_base),
		.live_o (page_live),
		.bank_o (bank)
	);

	// cable power pin into the clock domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cps_meta_q <= 1'b0;
			cps_q      <= 1'b0;
		end else begin
			cps_meta_q <= cps_pin_i;
			cps_q      <= cps_meta_q;
		end
	end

	// root holdoff, only a register write changes it
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rhb_q <= 1'b0;
		end else if (wr_gap) begin
			rhb_q <= wr_byte[PPRF_RHB_BIT]; // [R2] [R5]
		end
	end

	// bus reset request, cleared when the bus reset happens
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ibr_q <= 1'b0;
		end else if (wr_gap && wr_byte[PPRF_IBR_BIT]) begin
			ibr_q <= 1'b1; // new request wins over the clear
		end else if (bus_reset_i) begin
			ibr_q <= 1'b0;
		end
	end

	// gap count, back to its default after two unbroken bus resets
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gap_q    <= PPRF_GAP_RST;
			resets_q <= 2'h0;
		end else if (wr_gap) begin
			gap_q    <= wr_byte[5:0]; // [R2]
			resets_q <= 2'h0;
		end else if (bus_reset_i) begin
			if (resets_q == PPRF_RESETS_LIM - 2'h1) begin
				gap_q    <= PPRF_GAP_RST;
				resets_q <= 2'h0;
			end else begin
				resets_q <= resets_q + 2'h1;
			end
		end
	end

	// writable bits of registers three and four
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sren_q  <= 1'b0;
			lctrl_q <= 1'b0;
			cont_q  <= 1'b0;
			pwr_q   <= 3'h0;
		end else if (wr_speed) begin
			sren_q <= wr_byte[PPRF_SREN_BIT]; // [R2]
		end else if (wr_link) begin
			lctrl_q <= wr_byte[PPRF_LCTRL_BIT];
			cont_q  <= wr_byte[PPRF_C_BIT];
			pwr_q   <= wr_byte[2:0]; // jitter bits stay fixed [R2]
		end
	end

	// enables and bridge field
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			inten_q  <= PPRF_BYTE_RST;
			bridge_q <= 2'h0;
		end else if (wr_inten) begin
			inten_q <= wr_byte; // [R2]
		end else if (wr_legacy) begin
			bridge_q <= wr_byte[PPRF_BRIDGE_LSB +: 2];
		end
	end

	// page and port select, reserved bit dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			page_q <= 3'h0;
			port_q <= 4'h0;
		end else if (wr_page) begin
			page_q <= wr_byte[PPRF_PAGE_LSB +: 3]; // [R4] [R8]
			port_q <= wr_byte[PPRF_PORT_LSB +: 4];
		end
	end

	// paged storage, writes to reserved pages are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int b = 0; b < PPRF_NUM_BANKS; b++) begin
				for (int r = 0; r < PPRF_PAGE_REGS; r++) begin
					page_mem_q[b][r] <= PPRF_BYTE_RST;
				end
			end
		end else if (commit && mapped && page_live) begin
			page_mem_q[bank][idx[2:0]] <= wr_byte; // [R3] [R7]
		end
	end

	// read multiplexer, reserved places give zero
	always_comb begin
		rd_byte = 8'h00; // [R6]
		if (!mapped) begin
			rd_byte = 8'h00; // outside the window [R6]
		end else if (is_base) begin
			case (idx) // page never consulted here [R2] [R5]
				PPRF_IDX_NODE_ID:   rd_byte = {phy_id_i, root_i, cps_q};
				PPRF_IDX_GAP_CTRL:  rd_byte = {rhb_q, ibr_q, gap_q};
				PPRF_IDX_EXT_PORTS: rd_byte = {PPRF_EXT_VAL, 1'b0,
					PPRF_NPORTS_VAL};
				PPRF_IDX_SPEED:     rd_byte = {PPRF_SPEED_VAL, sren_q,
					PPRF_DELAY_VAL};
				PPRF_IDX_LINK_PWR:  rd_byte = {lctrl_q, cont_q,
					PPRF_JITTER_VAL, pwr_q};
				PPRF_IDX_INT_EN:    rd_byte = inten_q;
				PPRF_IDX_LEGACY:    rd_byte = {LEGACY_SPD, blink_i,
					bridge_q, 2'h0};
				PPRF_IDX_PAGE_SEL:  rd_byte = {page_q, 1'b0, port_q};
				default:            rd_byte = 8'h00;
			endcase
		end else if (page_live) begin
			rd_byte = page_mem_q[bank][idx[2:0]]; // [R3] [R4]
		end else begin
			rd_byte = 8'h00; // reserved page [R7]
		end
	end

	// read data captured when the request is taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_q <= 32'h0000_0000;
		end else if (take) begin
			dat_q <= {24'h00_0000, rd_byte}; // [R1] [R6]
		end
	end

	// outputs
	assign wb_dat_o        = dat_q;
	assign root_holdoff_o  = rhb_q;
	assign bus_reset_req_o = ibr_q;
	assign gap_count_o     = gap_q;
	assign standby_en_o    = sren_q;
	assign link_active_o   = lctrl_q;
	assign contender_o     = cont_q;
	assign pwr_class_o     = pwr_q;
	assign int_enables_o   = inten_q;
	assign bridge_o        = bridge_q;
	assign page_o          = page_q;
	assign port_sel_o      = port_q;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) // [R1]
		else $error("ack stood longer than one cycle");

	ack_follows_a: assert property (take |=> wb_ack_o) // [R1]
		else $error("no ack one cycle after request");

	rsvd_page_a: assert property ( // [R7]
		take && mapped && !is_base && pprf_page_rsvd(page_q)
		|=> wb_dat_o == 32'h0000_0000)
		else $error("reserved page read not zero");

	upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) // [R6]
		else $error("upper read bits not zero");

	unmapped_zero_a: assert property ( // [R6]
		take && !mapped |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	fixed_base_a: assert property ( // [R2]
		take && mapped && idx == PPRF_IDX_EXT_PORTS
		|=> wb_dat_o[7:0] == {PPRF_EXT_VAL, 1'b0, PPRF_NPORTS_VAL})
		else $error("fixed base register changed");

	base_page_free_a: assert property ( // [R5]
		take && mapped && idx == PPRF_IDX_GAP_CTRL
		|=> wb_dat_o[7:0] == {$past(rhb_q), $past(ibr_q),
			$past(gap_q)})
		else $error("base read depends on more than its fields");

	// page selection checks
	page_follow_a: assert property ( // [R4]
		wr_page |=> page_q == $past(wr_pg_val))
		else $error("page select not taken from register seven");

	port_follow_a: assert property ( // [R4]
		wr_page |=> port_q == $past(wr_pt_val))
		else $error("port select not taken from register seven");

	page_hold_a: assert property ( // [R8]
		$changed(page_q) |-> $past(wr_page))
		else $error("page changed without a page write");

	// read path of the pages
	page_zero_rd_a: assert property ( // [R3]
		take && mapped && !is_base && page_q == 3'h0
		|=> wb_dat_o[7:0] == $past(p0_byte))
		else $error("page zero read wrong slot");

	// flag and counter corners of register one, byte lane gating and read data hold
	ibr_wins_a: assert property ( // [R2]
		wr_gap && wr_byte[PPRF_IBR_BIT] |=> ibr_q)
		else $error("bus reset request lost");

	gap_reload_a: assert property ( // [R2]
		bus_reset_i && !wr_gap && resets_q == PPRF_RESETS_LIM - 2'h1
		|=> gap_q == PPRF_GAP_RST)
		else $error("gap count not reloaded");

	sel_gate_a: assert property ( // [R2]
		wb_ack_o && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we
		&& !wb_req_i.sel[0] |=> $stable(inten_q) && $stable(page_q))
		else $error("write with lane zero off changed a register");

	dat_hold_a: assert property (!take |=> $stable(wb_dat_o)) // [R1]
		else $error("read data moved without a request");

	rsvd_page_c: cover property (take && !is_base
		&& pprf_page_rsvd(page_q));
	page_write_c: cover property (commit && idx == PPRF_IDX_PAGE_SEL);
	paged_write_c: cover property (commit && mapped && page_live);
	// gap reload and unmapped access reached
	gap_reload_c: cover property (bus_reset_i
		&& resets_q == PPRF_RESETS_LIM - 2'h1);
	unmapped_rd_c: cover property (take && !mapped);

endmodule : pprf_regfile

// ==== src/pprf_pkg.sv ====
// package: register map, field layout and bus carrier of the paged register file
// Summary of operation
// R1: sixteen registers selected by four-bit address
// R2: addresses zero to seven are fixed base registers
// R3: addresses eight to fifteen follow selected page
// R4: selected page comes from base register seven
// R5: base registers behave alike on every page
// R6: reserved registers and fields read as zero
// R7: pages two to six read all zero
// R8: page write governs only later paged accesses
package pprf_pkg;

	// sizes of the register file and the bus
	localparam int unsigned PPRF_NUM_REGS  = 16;
	localparam int unsigned PPRF_REG_AW    = 4;
	localparam int unsigned PPRF_ADR_W     = 8;
	localparam int unsigned PPRF_NUM_BANKS = 3;
	localparam int unsigned PPRF_PAGE_REGS = 8;

	// register indices, byte address is four times the index
	localparam logic [3:0] PPRF_IDX_NODE_ID   = 4'h0;
	localparam logic [3:0] PPRF_IDX_GAP_CTRL  = 4'h1;
	localparam logic [3:0] PPRF_IDX_EXT_PORTS = 4'h2;
	localparam logic [3:0] PPRF_IDX_SPEED     = 4'h3;
	localparam logic [3:0] PPRF_IDX_LINK_PWR  = 4'h4;
	localparam logic [3:0] PPRF_IDX_INT_EN    = 4'h5;
	localparam logic [3:0] PPRF_IDX_LEGACY    = 4'h6;
	localparam logic [3:0] PPRF_IDX_PAGE_SEL  = 4'h7;
	localparam logic [3:0] PPRF_IDX_PAGED_LO  = 4'h8;

	// byte-address fields of the wishbone address
	localparam int unsigned PPRF_ADR_IDX_LSB = 2;
	localparam int unsigned PPRF_ADR_IDX_MSB = 5;
	localparam int unsigned PPRF_ADR_TOP_LSB = 6;

	// page numbers
	localparam logic [2:0] PPRF_PAGE_RSVD_LO = 3'h2;
	localparam logic [2:0] PPRF_PAGE_RSVD_HI = 3'h6;
	localparam logic [2:0] PPRF_PAGE_ONE     = 3'h1;
	localparam logic [1:0] PPRF_BANK_P0      = 2'h0;
	localparam logic [1:0] PPRF_BANK_P1      = 2'h1;
	localparam logic [1:0] PPRF_BANK_P7      = 2'h2;

	// field positions (lsb of each field)
	localparam int unsigned PPRF_RHB_BIT    = 7;
	localparam int unsigned PPRF_IBR_BIT    = 6;
	localparam int unsigned PPRF_SREN_BIT   = 4;
	localparam int unsigned PPRF_LCTRL_BIT  = 7;
	localparam int unsigned PPRF_C_BIT      = 6;
	localparam int unsigned PPRF_BLINK_BIT  = 4;
	localparam int unsigned PPRF_BRIDGE_LSB = 2;
	localparam int unsigned PPRF_PAGE_LSB   = 5;
	localparam int unsigned PPRF_PORT_LSB   = 0;

	// fixed values and values after reset
	localparam logic [5:0] PPRF_GAP_RST     = 6'h3f;
	localparam logic [2:0] PPRF_EXT_VAL     = 3'h7;
	localparam logic [3:0] PPRF_NPORTS_VAL  = 4'h3;
	localparam logic [2:0] PPRF_SPEED_VAL   = 3'h7;
	localparam logic [3:0] PPRF_DELAY_VAL   = 4'hf;
	localparam logic [2:0] PPRF_JITTER_VAL  = 3'h0;
	localparam logic [7:0] PPRF_BYTE_RST    = 8'h00;
	localparam logic [1:0] PPRF_RESETS_LIM  = 2'h2;

	// wishbone request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} pprf_wb_req_t;

	// true for a page whose paged registers are all reserved
	function automatic logic pprf_page_rsvd(input logic [2:0] page);
		return (page >= PPRF_PAGE_RSVD_LO) && (page <= PPRF_PAGE_RSVD_HI);
	endfunction : pprf_page_rsvd

endpackage : pprf_pkg

// ==== src/pprf_wb_port.sv ====
// module: classic wishbone slave handshake for the register file
`timescale 1ns/100ps
module pprf_wb_port (
	// clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// bus request
	input  wire pprf_pkg::pprf_wb_req_t wb_req_i,
	// handshake results
	output logic                     ack_o,
	output logic                     take_o,
	output logic                     commit_o,
	output logic [3:0]               idx_o,
	output logic                     mapped_o
);
	import pprf_pkg::*;

	logic ack_q; // acknowledge, one cycle per request
	logic live;  // request present on the bus

	// request present while cyc and stb stand
	assign live = wb_req_i.cyc & wb_req_i.stb;
	// request taken on the edge where ack is still low
	assign take_o = live & ~ack_q;
	// a write lands on the edge at which the master sees ack
	assign commit_o = live & ack_q & wb_req_i.we & wb_req_i.sel[0];
	// word index inside the sixteen-register window
	assign idx_o = wb_req_i.adr[PPRF_ADR_IDX_MSB:PPRF_ADR_IDX_LSB];
	// anything above the window is unmapped
	assign mapped_o = (wb_req_i.adr[PPRF_ADR_W-1:PPRF_ADR_TOP_LSB] == 2'h0);
	assign ack_o = ack_q;

	// ack rises one cycle after take and drops the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= take_o;
		end
	end

endmodule : pprf_wb_port

// ==== src/pprf_page_map.sv ====
// module: maps a register index and page number onto storage
`timescale 1ns/100ps
module pprf_page_map (
	// access
	input  wire logic [3:0] idx_i,
	input  wire logic [2:0] page_i,
	// decode
	output logic            base_o,
	output logic            live_o,
	output logic [1:0]      bank_o
);
	import pprf_pkg::*;

	// low half is the fixed base set
	assign base_o = (idx_i < PPRF_IDX_PAGED_LO);
	// paged slot backed by storage only on pages 0, 1 and 7
	assign live_o = ~base_o & ~pprf_page_rsvd(page_i);

	// bank select for the live pages
	always_comb begin
		case (page_i)
			3'h0:         bank_o = PPRF_BANK_P0;
			PPRF_PAGE_ONE: bank_o = PPRF_BANK_P1;
			default:      bank_o = PPRF_BANK_P7;
		endcase
	end

endmodule : pprf_page_map

// ==== test/pprf_llc_model.sv ====
// file: wishbone master model of the link-layer controller
`timescale 1ns/100ps
module pprf_llc_model (
	// clock
	input  wire logic              clk_i,
	// wishbone master side
	output pprf_pkg::pprf_wb_req_t wb_req_o,
	input  wire logic              wb_ack_i,
	input  wire logic [31:0]       wb_dat_i
);
	import pprf_pkg::*;

	pprf_wb_req_t r; // request being built

	// bus idle from time zero
	initial begin
		r = '0;
		wb_req_o = '0;
	end

	// one classic cycle, held until ack is sampled high
	task automatic xfer(input logic we, input logic [7:0] adr,
		input logic [3:0] sel, input logic [31:0] dat,
		output logic [31:0] q);
		@(posedge clk_i);
		r.cyc = 1'b1;
		r.stb = 1'b1;
		r.we = we;
		r.adr = adr;
		r.sel = sel;
		r.dat = dat;
		wb_req_o <= r;
		@(posedge clk_i);
		while (wb_ack_i !== 1'b1) begin
			@(posedge clk_i);
		end
		q = wb_dat_i;
		// released data lines show the inverse, never the stale value
		r.cyc = 1'b0;
		r.stb = 1'b0;
		r.dat = ~r.dat;
		wb_req_o <= r;
	endtask : xfer
endmodule : pprf_llc_model

// ==== test/test_phy_paged_register_file.sv ====
// file: self-checking bench of the paged register file
`timescale 1ns/100ps
module test_phy_paged_register_file;
	import pprf_pkg::*;

	logic         clk_i;       // bench clock
	logic         rst_i;       // synchronous reset
	pprf_wb_req_t wb_req;      // bus request from the model
	logic         wb_ack;      // bus ack
	logic [31:0]  wb_dat;      // bus read data
	logic [5:0]   phy_id_i;    // node id
	logic         root_i;      // root flag
	logic         cps_pin_i;   // cable power pin
	logic         blink_i;     // bridge link flag
	logic         bus_reset_i; // bus reset pulse
	logic         rhb, ibr, sren, lact, cont;
	logic [5:0]   gap;
	logic [2:0]   pwr, page;
	logic [7:0]   ints;
	logic [1:0]   bridge;
	logic [3:0]   port;
	int           fail_count;  // mismatches
	int           n_checks;    // comparisons
	int           cycles;      // timeout counter
	// expected base values after reset, legacy speed set to 5
	logic [7:0]   rst_tab [8] = '{8'hab, 8'h3f, 8'he3, 8'hef,
		8'h00, 8'h00, 8'hb0, 8'h00};

	pprf_regfile #(.LEGACY_SPD(3'h5)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
		.wb_ack_o(wb_ack), .wb_dat_o(wb_dat), .phy_id_i(phy_id_i),
		.root_i(root_i), .cps_pin_i(cps_pin_i), .blink_i(blink_i),
		.bus_reset_i(bus_reset_i), .root_holdoff_o(rhb),
		.bus_reset_req_o(ibr), .gap_count_o(gap), .standby_en_o(sren),
		.link_active_o(lact), .contender_o(cont), .pwr_class_o(pwr),
		.int_enables_o(ints), .bridge_o(bridge), .page_o(page),
		.port_sel_o(port));

	pprf_llc_model llc (.clk_i(clk_i), .wb_req_o(wb_req),
		.wb_ack_i(wb_ack), .wb_dat_i(wb_dat));

	// clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fail_count++;
			summarize();
		end
	end

	// compare and count
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// byte address of a register index
	function automatic logic [7:0] ad(input logic [3:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ad

	// write one byte, upper word bits set to show they are dropped
	task automatic wr(input logic [7:0] a, input logic [7:0] v,
		input logic [3:0] sel = 4'h1);
		logic [31:0] q;
		llc.xfer(1'b1, a, sel, {24'hffffff, v}, q);
	endtask : wr

	// read one byte and compare
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		logic [31:0] q;
		llc.xfer(1'b0, a, 4'h1, 32'h0, q);
		chk(nm, {24'h0, e}, q);
	endtask : rd

	// one bus reset pulse
	task automatic pulse;
		@(posedge clk_i);
		bus_reset_i <= 1'b1;
		@(posedge clk_i);
		bus_reset_i <= 1'b0;
	endtask : pulse

	// base registers after reset
	task automatic t_reset;
		for (int i = 0; i < 8; i++) begin
			rd(ad(i[3:0]), rst_tab[i], "reset_base");
		end
		$display("test reset done");
	endtask : t_reset

	// writable fields, read-only fields, byte enable
	task automatic t_base;
		wr(ad(4'h1), 8'hc5);
		rd(ad(4'h1), 8'hc5, "reg1");
		chk("ctrl1", 8'hc5, {rhb, ibr, gap});
		wr(ad(4'h4), 8'hff);
		rd(ad(4'h4), 8'hc7, "reg4");
		chk("ctrl4", 5'h1f, {lact, cont, pwr});
		wr(ad(4'h5), 8'ha5);
		wr(ad(4'h5), 8'h00, 4'h0);
		rd(ad(4'h5), 8'ha5, "reg5");
		chk("ints", 8'ha5, ints);
		wr(ad(4'h2), 8'hff);
		rd(ad(4'h2), 8'he3, "reg2");
		wr(ad(4'h0), 8'h00);
		rd(ad(4'h0), 8'hab, "reg0");
		wr(ad(4'h3), 8'hff);
		rd(ad(4'h3), 8'hff, "reg3");
		wr(ad(4'h6), 8'hff);
		rd(ad(4'h6), 8'hbc, "reg6");
		chk("ctrl36", 3'h7, {sren, bridge});
		$display("test base done");
	endtask : t_base

	// bus reset clears initiate bit, second one reloads gap
	task automatic t_busreset;
		pulse();
		rd(ad(4'h1), 8'h85, "reg1_br1");
		pulse();
		rd(ad(4'h1), 8'hbf, "reg1_br2");
		chk("gap", 6'h3f, gap);
		$display("test bus reset done");
	endtask : t_busreset

	// paged writes on every page, only pages 0, 1 and 7 keep them, reserved pages read zero
	task automatic t_pages;
		logic [2:0] pg;
		logic [3:0] ix;
		logic [7:0] e;
		for (int p = 0; p < 8; p++) begin
			pg = p[2:0];
			wr(ad(4'h7), {pg, 1'b1, 4'h9});
			rd(ad(4'h5), 8'ha5, "base_on_page");
			chk("page", {pg, 4'h9}, {page, port});
			for (int i = 8; i < 16; i++) begin
				ix = i[3:0];
				wr(ad(ix), {pg, 1'b1, ix});
			end
		end
		for (int p = 7; p >= 0; p--) begin
			pg = p[2:0];
			wr(ad(4'h7), {pg, 1'b0, 4'h9});
			for (int i = 8; i < 16; i++) begin
				ix = i[3:0];
				e = {pg, 1'b1, ix};
				if (pg >= 3'h2 && pg <= 3'h6) begin
					e = 8'h00;
				end
				rd(ad(ix), e, "paged");
			end
		end
		wr(ad(4'h7), 8'hff);
		rd(ad(4'h7), 8'hef, "reg7");
		$display("test pages done");
	endtask : t_pages

	// unmapped addresses read zero and ignore writes
	task automatic t_unmapped;
		rd(8'h40, 8'h00, "unmapped");
		wr(8'h7c, 8'h00);
		rd(ad(4'hf), 8'hff, "alias");
		$display("test unmapped done");
	endtask : t_unmapped

	// pin-driven fields follow their inputs
	task automatic t_pins;
		cps_pin_i <= 1'b0;
		root_i <= 1'b0;
		blink_i <= 1'b0;
		phy_id_i <= 6'h15;
		repeat (2) @(posedge clk_i);
		rd(ad(4'h0), 8'h54, "reg0_pins");
		rd(ad(4'h6), 8'hac, "reg6_pins");
		$display("test pins done");
	endtask : t_pins

	// counts and verdict
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		fail_count = 0;
		n_checks = 0;
		cycles = 0;
		rst_i = 1'b1;
		phy_id_i = 6'h2a;
		root_i = 1'b1;
		cps_pin_i = 1'b1;
		blink_i = 1'b1;
		bus_reset_i = 1'b0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_base();
		t_busreset();
		t_pages();
		t_unmapped();
		t_pins();
		summarize();
	end
endmodule : test_phy_paged_register_file
